// File: adcc_pkg.sv
// Shared constants for the converter control block.
`default_nettype none
package adcc_pkg;
  localparam logic [7:0] ADCC_OFS_AUX0 = 8'h8e;
  localparam logic [7:0] ADCC_OFS_RESULT_LOW = 8'hbe;
  localparam logic [7:0] ADCC_OFS_CTRL = 8'hc5;
  localparam logic [7:0] ADCC_OFS_RESULT_HIGH = 8'hc6;
  localparam int ADCC_CTRL_POWER_BIT = 7;
  localparam int ADCC_CTRL_SPEED_HI_BIT = 6;
  localparam int ADCC_CTRL_SPEED_LO_BIT = 5;
  localparam int ADCC_CTRL_DONE_BIT = 4;
  localparam int ADCC_CTRL_GO_BIT = 3;
  localparam int ADCC_CTRL_CHAN_MSB = 2;
  localparam int ADCC_AUX_JUSTIFY_BIT = 2;
  localparam logic [7:0] ADCC_CTRL_RESET = 8'h00;
  localparam logic [7:0] ADCC_RESULT_RESET = 8'h00;
  localparam logic [7:0] ADCC_UNMAPPED_READ = 8'h00;
  // Conversion length in system clocks is this unit times (speed code + 1).
  localparam logic [7:0] ADCC_DIV_UNIT = 8'h3c;
  localparam int ADCC_CNT_W = 8;

  typedef logic [1:0] adcc_speed_t;

  function automatic logic [ADCC_CNT_W-1:0] adcc_divisor(input adcc_speed_t sel);
    logic [9:0] prod;
    prod = 10'(ADCC_DIV_UNIT) * (10'(sel) + 10'h001);
    return prod[ADCC_CNT_W-1:0];
  endfunction
endpackage
`default_nettype wire

// File: adcc_conv_if.sv
// Interface joining the controller to its sequencer and result packer.
`default_nettype none
interface adcc_conv_if;
  logic start;
  logic run;
  adcc_pkg::adcc_speed_t speed;
  logic done;
  logic [9:0] raw;
  logic justify;
  logic [7:0] high_byte;
  logic [7:0] low_byte;
  modport ctrl (output start, run, speed, raw, justify, input done, high_byte, low_byte);
  modport seq (input start, run, speed, output done);
  modport pack (input done, raw, justify, output high_byte, low_byte);
endinterface
`default_nettype wire

// File: adcc_sequencer.sv
// Conversion timer: counts the selected divisor and pulses done at the end.
`default_nettype none
module adcc_sequencer
(
  input wire logic clock,
  input wire logic reset,
  adcc_conv_if.seq cif
);
  import adcc_pkg::*;

  logic busy_q;
  logic [ADCC_CNT_W-1:0] count_q;
  wire [ADCC_CNT_W-1:0] limit = adcc_divisor(cif.speed);
  wire last = busy_q && cif.run && (count_q >= limit);

  // The count pauses while the converter may not run.
  assign cif.done = last;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      busy_q <= 1'b0;
      count_q <= '0;
    end
    else if (cif.start)
    begin
      busy_q <= 1'b1;
      count_q <= 8'h01;
    end
    else if (last)
      busy_q <= 1'b0;
    else if (busy_q && cif.run)
      count_q <= count_q + 8'h01;
  end

  a_done_when_busy: assert property (@(posedge clock) disable iff (reset)
    cif.done |-> busy_q) else $error("done without a running conversion");
endmodule
`default_nettype wire

// File: adcc_result_pack.sv
// Result byte pair, loaded and packed at conversion completion.
`default_nettype none
module adcc_result_pack
(
  input wire logic clock,
  input wire logic reset,
  adcc_conv_if.pack cif
);
  import adcc_pkg::*;

  logic [7:0] high_q;
  logic [7:0] low_q;
  wire [7:0] high_d = cif.justify ? {6'h00, cif.raw[9:8]} : cif.raw[9:2];
  wire [7:0] low_d = cif.justify ? cif.raw[7:0] : {6'h00, cif.raw[1:0]};

  assign cif.high_byte = high_q;
  assign cif.low_byte = low_q;

  // Packing is fixed when stored, so a later justify change leaves it alone.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      high_q <= ADCC_RESULT_RESET;
      low_q <= ADCC_RESULT_RESET;
    end
    else if (cif.done)
    begin
      high_q <= high_d;
      low_q <= low_d;
    end
  end

  a_pack_right: assert property (@(posedge clock) disable iff (reset)
    cif.done && cif.justify |=> low_q == $past(cif.raw[7:0]) && high_q[7:2] == 6'h00)
    else $error("right justified packing wrong");
  a_pack_left: assert property (@(posedge clock) disable iff (reset)
    cif.done && !cif.justify |=> high_q == $past(cif.raw[9:2]) && low_q[7:2] == 6'h00)
    else $error("left justified packing wrong");
  a_hold_result: assert property (@(posedge clock) disable iff (reset)
    !cif.done |=> $stable(high_q) && $stable(low_q))
    else $error("result changed without completion");
endmodule
`default_nettype wire

// File: adcc_top.sv
// Converter control: special function registers, start logic and core drive.
`default_nettype none
module adcc_top
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic cpu_idle,
  input wire logic cpu_power_down,
  input wire logic irq_enable,
  input wire logic [9:0] core_result,
  output logic converter_power_on,
  output logic [2:0] core_channel,
  output logic core_converting,
  output logic irq_request
);
  import adcc_pkg::*;

  adcc_conv_if cif ();

  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic justify_q;
  logic justify_d;
  logic [7:0] rdata_q;
  logic irq_q;

  wire ctrl_wr = sfr_wr && (sfr_addr == ADCC_OFS_CTRL);
  wire aux_wr = sfr_wr && (sfr_addr == ADCC_OFS_AUX0);
  wire go_q = ctrl_q[ADCC_CTRL_GO_BIT];
  wire done_q = ctrl_q[ADCC_CTRL_DONE_BIT];
  wire power_q = ctrl_q[ADCC_CTRL_POWER_BIT];
  wire done_pulse = cif.done;
  wire sleeping = cpu_idle || cpu_power_down;
  wire run = power_q && !sleeping;

  // A start needs power on in the written value, no sleep, and both flags clear.
  wire start_req = ctrl_wr && sfr_wdata[ADCC_CTRL_GO_BIT];
  wire start = start_req && sfr_wdata[ADCC_CTRL_POWER_BIT] && !sleeping
               && !go_q && !done_q;

  // Software may rewrite power, speed and channel at any time.
  wire [7:0] ctrl_sw = ctrl_wr ? sfr_wdata : ctrl_q;
  // Writing zero to go never clears it; only completion does.
  wire go_d = start || (go_q && !done_pulse);
  // Completion wins over a software clear in the same cycle.
  wire done_d = done_pulse || (ctrl_wr ? sfr_wdata[ADCC_CTRL_DONE_BIT] : done_q);

  always_comb
  begin
    ctrl_d = ctrl_sw;
    ctrl_d[ADCC_CTRL_GO_BIT] = go_d;
    ctrl_d[ADCC_CTRL_DONE_BIT] = done_d;
  end

  assign justify_d = aux_wr ? sfr_wdata[ADCC_AUX_JUSTIFY_BIT] : justify_q;

  wire [7:0] aux_read = 8'(justify_q) << ADCC_AUX_JUSTIFY_BIT;
  wire [7:0] read_mux = (sfr_addr == ADCC_OFS_CTRL) ? ctrl_q :
                        (sfr_addr == ADCC_OFS_AUX0) ? aux_read :
                        (sfr_addr == ADCC_OFS_RESULT_HIGH) ? cif.high_byte :
                        (sfr_addr == ADCC_OFS_RESULT_LOW) ? cif.low_byte :
                        ADCC_UNMAPPED_READ;

  assign cif.start = start;
  assign cif.run = run;
  assign cif.speed = ctrl_q[ADCC_CTRL_SPEED_HI_BIT:ADCC_CTRL_SPEED_LO_BIT];
  assign cif.raw = core_result;
  assign cif.justify = justify_q;

  adcc_sequencer u_sequencer
  (
    .clock(clock),
    .reset(reset),
    .cif(cif)
  );

  adcc_result_pack u_result_pack
  (
    .clock(clock),
    .reset(reset),
    .cif(cif)
  );

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ctrl_q <= ADCC_CTRL_RESET;
      justify_q <= 1'b0;
      rdata_q <= ADCC_UNMAPPED_READ;
      irq_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      justify_q <= justify_d;
      if (sfr_rd)
        rdata_q <= read_mux;
      irq_q <= done_d && irq_enable;
    end
  end

  assign sfr_rdata = rdata_q;
  assign converter_power_on = power_q;
  assign core_channel = ctrl_q[ADCC_CTRL_CHAN_MSB:0];
  assign core_converting = go_q;
  assign irq_request = irq_q;

  a_go_clears: assert property (@(posedge clock) disable iff (reset)
    done_pulse |=> !go_q && done_q) else $error("completion did not update flags");
  a_flag_kept: assert property (@(posedge clock) disable iff (reset)
    done_q && !ctrl_wr |=> done_q) else $error("hardware cleared the done flag");
  a_go_held: assert property (@(posedge clock) disable iff (reset)
    go_q && !done_pulse |=> go_q) else $error("go bit cleared without completion");
  a_no_restart: assert property (@(posedge clock) disable iff (reset)
    (go_q || done_q) |-> !cif.start) else $error("start while flags set");
  a_start_sets: assert property (@(posedge clock) disable iff (reset)
    start_req && !go_q && !done_q && sfr_wdata[ADCC_CTRL_POWER_BIT] && !sleeping
    |=> go_q ##1 (go_q && !done_pulse)[*8]) else $error("start did not begin");
  a_sleep_stall: assert property (@(posedge clock) disable iff (reset)
    sleeping |-> !done_pulse && !cif.start) else $error("conversion ran in sleep");
  a_reset_zero: assert property (@(posedge clock)
    reset |=> ctrl_q == ADCC_CTRL_RESET) else $error("control not zero after reset");
  a_irq_raise: assert property (@(posedge clock) disable iff (reset)
    done_pulse && irq_enable |=> irq_request) else $error("no interrupt request");
  a_channel_route: assert property (@(posedge clock) disable iff (reset)
    ctrl_wr |=> core_channel == $past(sfr_wdata[2:0])) else $error("channel not routed");

  c_start: cover property (@(posedge clock) disable iff (reset) cif.start);
  c_done_right: cover property (@(posedge clock) disable iff (reset) done_pulse && justify_q);
  c_blocked: cover property (@(posedge clock) disable iff (reset) start_req && done_q);
  c_clear_race: cover property (@(posedge clock) disable iff (reset) done_pulse && ctrl_wr);
endmodule
`default_nettype wire

// File: adcc_core_model.sv
// Behavioural analog core and input multiplexer facing the converter control.
`default_nettype none
module adcc_core_model
(
  input wire logic clock,
  input wire logic converter_power_on,
  input wire logic [2:0] core_channel,
  input wire logic core_converting,
  output logic [9:0] core_result
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] drift_q = 10'h000;
  // Only the multiplexer reads the analog inputs; no digital driver shares them.
  wire logic [9:0] sample = {core_channel ^ 3'h5, 4'h9, core_channel};
  always_ff @(posedge clock)
    drift_q <= drift_q + 10'h1a7;
  // Outside a powered conversion the lines wander, so a stale sample shows up.
  assign core_result = (converter_power_on && core_converting) ? sample : drift_q;
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench for the converter control block.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import adcc_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic cpu_idle = 1'b0;
  logic cpu_power_down = 1'b0;
  logic irq_enable = 1'b0;
  logic [7:0] sfr_rdata;
  logic [9:0] core_result;
  logic [2:0] core_channel;
  logic converter_power_on;
  logic core_converting;
  logic irq_request;
  int bad_count = 0;
  int checked = 0;
  adcc_top u_adcc_top (.clock, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .cpu_idle, .cpu_power_down, .irq_enable, .core_result, .converter_power_on,
    .core_channel, .core_converting, .irq_request);
  adcc_core_model u_adcc_core_model (.clock, .converter_power_on, .core_channel,
    .core_converting, .core_result);
  always #25 clock = ~clock;
  task automatic summarize();
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  // Bus tasks start and end at a falling edge and leave one idle cycle behind.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
    @(negedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clock);
    sfr_rd = 1'b0;
    check(16'(sfr_rdata), 16'(exp), what);
    @(negedge clock);
  endtask
  task automatic wait_end(output int n);
    n = 0;
    while (core_converting === 1'b1 && n < 1000)
    begin
      n++;
      @(negedge clock);
    end
    if (n >= 1000)
    begin
      bad_count++;
      summarize();
    end
  endtask
  task automatic t_conv(input logic [1:0] sp, input logic [2:0] ch, input logic jr, ie);
    logic [9:0] r;
    int n;
    r = {ch ^ 3'h5, 4'h9, ch};
    irq_enable = ie;
    wr(ADCC_OFS_AUX0, {5'h00, jr, 2'h0});
    wr(ADCC_OFS_CTRL, {1'b1, sp, 2'b00, ch});
    wr(ADCC_OFS_CTRL, {1'b1, sp, 2'b01, ch});
    check(16'(core_channel), 16'(ch), "channel");
    check(16'(converter_power_on), 16'h1, "power");
    wait_end(n);
    // The start write consumed one of the counted cycles.
    check(16'(n), 16'(60 * (sp + 1) - 1), "length");
    rd(ADCC_OFS_CTRL, {1'b1, sp, 2'b10, ch}, "done");
    check(16'(irq_request), 16'(ie), "irq");
    rd(ADCC_OFS_RESULT_HIGH, jr ? {6'h00, r[9:8]} : r[9:2], "high");
    rd(ADCC_OFS_RESULT_LOW, jr ? r[7:0] : {6'h00, r[1:0]}, "low");
    wr(ADCC_OFS_AUX0, {5'h00, ~jr, 2'h0});
    rd(ADCC_OFS_RESULT_HIGH, jr ? {6'h00, r[9:8]} : r[9:2], "repack");
    rd(ADCC_OFS_RESULT_LOW, jr ? r[7:0] : {6'h00, r[1:0]}, "repack low");
    $display("conversion test done, speed %0d", sp);
  endtask
  task automatic t_refuse();
    int n;
    wr(ADCC_OFS_CTRL, 8'h98);
    check(16'(core_converting), 16'h0, "start with done");
    wr(ADCC_OFS_CTRL, 8'h80);
    cpu_idle = 1'b1;
    wr(ADCC_OFS_CTRL, 8'h88);
    check(16'(core_converting), 16'h0, "idle");
    cpu_idle = 1'b0;
    cpu_power_down = 1'b1;
    wr(ADCC_OFS_CTRL, 8'h88);
    check(16'(core_converting), 16'h0, "power-down");
    cpu_power_down = 1'b0;
    wr(ADCC_OFS_CTRL, 8'h88);
    check(16'(core_converting), 16'h1, "start");
    wr(ADCC_OFS_CTRL, 8'h80);
    rd(ADCC_OFS_CTRL, 8'h88, "go clear ignored");
    wait_end(n);
    repeat (5) @(negedge clock);
    rd(ADCC_OFS_CTRL, 8'h90, "done kept");
    rd(ADCC_OFS_RESULT_HIGH, 8'hb2, "high");
    wr(ADCC_OFS_RESULT_HIGH, 8'h5b);
    rd(ADCC_OFS_RESULT_HIGH, 8'hb2, "read-only");
    rd(8'h01, ADCC_UNMAPPED_READ, "unmapped");
    wr(ADCC_OFS_CTRL, 8'h00);
    check(16'(converter_power_on), 16'h0, "power off");
    // The converter is switched off before the core goes to sleep.
    cpu_power_down = 1'b1;
    wr(ADCC_OFS_CTRL, 8'h08);
    check(16'(core_converting), 16'h0, "off and asleep");
    check(16'(converter_power_on), 16'h0, "stays off");
    cpu_power_down = 1'b0;
    $display("refusal test done");
  endtask
  task automatic t_pause();
    int n;
    wr(ADCC_OFS_CTRL, 8'h83);
    wr(ADCC_OFS_CTRL, 8'h8b);
    cpu_idle = 1'b1;
    repeat (10) @(negedge clock);
    check(16'(core_converting), 16'h1, "idle pause");
    cpu_idle = 1'b0;
    wait_end(n);
    // Go stands for 60 plus 10 paused cycles; eleven of those, one in the start write, pass before the wait.
    check(16'(n), 16'(60 + 10 - 1 - 10), "paused length");
    wr(ADCC_OFS_CTRL, 8'h83);
    wr(ADCC_OFS_CTRL, 8'h8b);
    repeat (3) @(negedge clock);
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    check(16'(core_converting), 16'h0, "reset go");
    check(16'(converter_power_on), 16'h0, "reset power");
    rd(ADCC_OFS_CTRL, ADCC_CTRL_RESET, "mid reset");
    rd(ADCC_OFS_RESULT_HIGH, ADCC_RESULT_RESET, "result reset");
    wr(ADCC_OFS_CTRL, 8'h88);
    wait_end(n);
    check(16'(n), 16'(60 - 1), "length after reset");
    $display("pause and reset test done");
  endtask
  initial
  begin
    repeat (8) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    rd(ADCC_OFS_CTRL, 8'h00, "reset");
    check(16'(converter_power_on), 16'h0, "reset power");
    $display("reset test done");
    t_conv(2'd0, 3'd0, 1'b0, 1'b1);
    t_conv(2'd1, 3'd7, 1'b1, 1'b0);
    t_conv(2'd2, 3'd5, 1'b0, 1'b1);
    t_conv(2'd3, 3'd2, 1'b1, 1'b1);
    wr(ADCC_OFS_AUX0, 8'h00);
    t_pause();
    t_refuse();
    summarize();
  end
endmodule
`default_nettype wire
